// *** pdmdac_top.sv ***
// PDM audio DAC controller: sample FIFO, DAC timer, modulator and I/O registers
// How it works
// - Sample period is 2^bits PDM clock ticks
// - PDM clock is mclk or mclk halved
// - Halver clear gives half rate, set full
// - Rate steps follow master clock steps
// - PLL multiplier sets the master clock rate
// - Resolution 8/9/10 bits in control bits 1:0
// - Enable bit clear holds both pins low
// - Re-enabling restarts from the zero state
// - Reset clears all four control bits
// - Sample interrupt once per sample period
// - Interrupt from timer underflow, vector 0x7FF0
// - Data register: 16-bit write-only sign-magnitude
// - Overflow bits 14:13, magnitude from bit 12
// - Control bit 3 picks drive style
// - Saturating style: overflow gives full density
// - Output is PDM on two pins
// - Enabled interrupt can wake the device
// - Events during wake-up may be lost
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module pdmdac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pdmdac_fifo: DEPTH must be a power of two of at least 2");
  end

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      // Registered so a full FIFO refuses the very next write
      in_ready <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule

// ------------------------------------------------------------------
// DAC controller top
// ------------------------------------------------------------------
module pdmdac_top #(
  parameter int FIFO_DEPTH = pdmdac_pkg::SAMPLE_FIFO_DEPTH
) (
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  input  wire pdmdac_pkg::pdmdac_io_req_t io_req,
  output logic [15:0]                     io_rdata,
  output logic                            sample_fifo_ready,
  input  wire logic                       pdm_rate_halver,
  input  wire logic                       low_power_mode,
  input  wire logic                       wake_settling,
  output logic                            sample_tick_irq,
  output logic [15:0]                     sample_irq_vector,
  output logic                            wake_request,
  output logic                            pdm_out_pos,
  output logic                            pdm_out_neg
);
  import pdmdac_pkg::*;

  pdmdac_ctrl_t ctl_reg;
  logic [15:0]  word_reg;
  logic [9:0]   timer_reg;
  logic [9:0]   acc_reg;
  logic         phase_reg;
  logic [9:0]   top;
  logic [9:0]   mag;
  logic [10:0]  sum;
  logic         carry;
  logic         pdm_tick;
  logic         underflow;
  logic         overflow;
  logic         pulse;
  logic         fifo_valid;
  logic [15:0]  fifo_data;

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg <= DAC_CONTROL_RESET;
    end else if (io_req.wr && io_req.addr == ADDR_DAC_CONTROL) begin
      ctl_reg <= io_req.wdata[3:0];
    end
  end

  // Data register reads back zero: it is write-only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= 16'h0000;
    end else if (io_req.rd && io_req.addr == ADDR_DAC_CONTROL) begin
      io_rdata <= {12'h000, ctl_reg};
    end else begin
      io_rdata <= 16'h0000;
    end
  end

  pdmdac_fifo #(
    .WIDTH (WORD_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_valid  (io_req.wr && io_req.addr == ADDR_SAMPLE_DATA),
    .in_ready  (sample_fifo_ready),
    .in_data   (io_req.wdata),
    .out_valid (fifo_valid),
    .out_ready (underflow),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // PDM clock and resolution decode
  // ----------------------------------------------------------------
  // mclk is the PLL output, so rate and steps follow the multiplier
  assign pdm_tick = ctl_reg.enable && (pdm_rate_halver || phase_reg);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= 1'b0;
    end else if (!ctl_reg.enable || pdm_rate_halver) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  always_comb begin
    case (ctl_reg.resolution)
      RES_8: begin
        top = TOP_8;
        mag = {2'b00, word_reg[MAG_HI_POS:MAG_LO_8]};
        carry = sum[8];
      end
      RES_9: begin
        top = TOP_9;
        mag = {1'b0, word_reg[MAG_HI_POS:MAG_LO_9]};
        carry = sum[9];
      end
      default: begin
        top = TOP_10;
        mag = word_reg[MAG_HI_POS:MAG_LO_10];
        carry = sum[10];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // DAC timer and sample load
  // ----------------------------------------------------------------
  // Counts up to the top, so a resolution written with enable holds at once
  assign underflow = pdm_tick && (timer_reg >= top);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_reg <= 10'h000;
    end else if (!ctl_reg.enable) begin
      timer_reg <= 10'h000;
    end else if (pdm_tick) begin
      timer_reg <= underflow ? 10'h000 : timer_reg + 10'h001;
    end
  end

  // An empty FIFO at underflow repeats the last sample
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      word_reg <= SAMPLE_DATA_RESET;
    end else if (underflow && fifo_valid) begin
      word_reg <= fifo_data;
    end
  end

  // ----------------------------------------------------------------
  // Modulator
  // ----------------------------------------------------------------
  assign sum = {1'b0, acc_reg} + {1'b0, mag};
  // Alternate style lets overflow bits wrap, so only saturating clamps
  assign overflow = word_reg[OVF_HI_POS] || word_reg[OVF_LO_POS];
  assign pulse = carry || (overflow && !ctl_reg.drive_style);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= 10'h000;
    end else if (!ctl_reg.enable) begin
      acc_reg <= 10'h000;
    end else if (pdm_tick) begin
      acc_reg <= sum[9:0] & top;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pdm_out_pos <= 1'b0;
      pdm_out_neg <= 1'b0;
    end else if (!ctl_reg.enable) begin
      pdm_out_pos <= 1'b0;
      pdm_out_neg <= 1'b0;
    end else if (pdm_tick) begin
      pdm_out_pos <= pulse && !word_reg[SIGN_POS];
      pdm_out_neg <= pulse && word_reg[SIGN_POS];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and wake
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sample_tick_irq <= 1'b0;
      wake_request <= 1'b0;
      sample_irq_vector <= SAMPLE_IRQ_VECTOR;
    end else begin
      sample_tick_irq <= underflow && !wake_settling;
      wake_request <= underflow && low_power_mode;
      sample_irq_vector <= SAMPLE_IRQ_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [11:0] gap_cnt;
  logic        gap_ok;
  logic [3:0]  cfg_q;
  logic [11:0] gap_expect;

  assign gap_expect = pdm_rate_halver ? 12'(top) + 12'h001 : (12'(top) + 12'h001) << 1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt <= 12'h000;
      gap_ok <= 1'b0;
      cfg_q <= 4'h0;
    end else begin
      cfg_q <= {pdm_rate_halver, ctl_reg.enable, ctl_reg.resolution};
      if (underflow) begin
        gap_cnt <= 12'h001;
        gap_ok <= 1'b1;
      end else begin
        gap_cnt <= gap_cnt + 12'h001;
        if (cfg_q != {pdm_rate_halver, ctl_reg.enable, ctl_reg.resolution}) begin
          gap_ok <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_PERIOD: assert property (underflow && gap_ok |-> gap_cnt == gap_expect)
    else $error("sample period does not match rate and resolution");
  AST_HALF_RATE: assert property (!pdm_rate_halver && pdm_tick |=> !pdm_tick)
    else $error("halved PDM clock ticked twice in a row");
  AST_TICK_ALT: assert property ((ctl_reg.enable && !pdm_rate_halver)[*2] |-> pdm_tick != $past(pdm_tick))
    else $error("halved PDM clock does not alternate");
  AST_DISABLED_LOW: assert property (!ctl_reg.enable |=> !pdm_out_pos && !pdm_out_neg)
    else $error("pins pulse while disabled");
  AST_REENABLE_ZERO: assert property ($fell(ctl_reg.enable) |=> acc_reg == 10'h000 ##1 !pdm_out_pos)
    else $error("modulator not returned to zero");
  AST_SATURATE: assert property (pdm_tick && overflow && !ctl_reg.drive_style |=> pdm_out_pos || pdm_out_neg)
    else $error("overflow did not give full density");
  AST_ONE_PIN: assert property (!(pdm_out_pos && pdm_out_neg))
    else $error("both pins driven at once");
  AST_WO_READ: assert property (io_req.rd && io_req.addr == ADDR_SAMPLE_DATA |=> io_rdata == 16'h0000)
    else $error("data register read back nonzero");
  AST_IRQ_CAUSE: assert property (sample_tick_irq |-> $past(underflow) && !$past(wake_settling))
    else $error("interrupt without timer underflow");
  AST_WAKE: assert property (underflow && low_power_mode |=> wake_request)
    else $error("underflow in low power did not request wake");

  COV_IRQ_8BIT: cover property (sample_tick_irq && ctl_reg.resolution == RES_8);
  COV_SATURATE: cover property (pdm_tick && overflow && !ctl_reg.drive_style);
  COV_FIFO_FULL: cover property (!sample_fifo_ready);
  COV_NEG_PULSE: cover property (pdm_out_neg);
endmodule

`default_nettype wire

// *** pdmdac_pkg.sv ***
// Constants and carrier types for the PDM audio DAC controller
package pdmdac_pkg;
  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_SAMPLE_DATA = 8'h30;
  localparam logic [7:0]  ADDR_DAC_CONTROL = 8'h34;
  localparam logic [3:0]  DAC_CONTROL_RESET = 4'h0;
  localparam logic [15:0] SAMPLE_DATA_RESET = 16'h0000;
  localparam logic [15:0] SAMPLE_IRQ_VECTOR = 16'h7ff0;
  localparam int          WORD_WIDTH = 16;
  localparam int          SAMPLE_FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Field positions and resolution codes
  // ----------------------------------------------------------------
  localparam int SIGN_POS = 15;
  localparam int OVF_HI_POS = 14;
  localparam int OVF_LO_POS = 13;
  localparam int MAG_HI_POS = 12;
  localparam int MAG_LO_8 = 5;
  localparam int MAG_LO_9 = 4;
  localparam int MAG_LO_10 = 3;
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_9 = 2'h1;
  localparam logic [9:0] TOP_8 = 10'h0ff;
  localparam logic [9:0] TOP_9 = 10'h1ff;
  localparam logic [9:0] TOP_10 = 10'h3ff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       drive_style;
    logic       enable;
    logic [1:0] resolution;
  } pdmdac_ctrl_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } pdmdac_io_req_t;
endpackage

// *** pdmdac_speaker.sv ***
// Loudspeaker load model: integrates activity on the two PDM pins
`timescale 1ns/1ps
`default_nettype none
module pdmdac_speaker (
  input  wire logic mclk,
  input  wire logic pdm_out_pos,
  input  wire logic pdm_out_neg,
  output int        pos_count,
  output int        neg_count,
  output int        clash_count
);
  // ------------------------------------------------------------
  // Coil current
  // ------------------------------------------------------------
  // Passive load; both pins high would short the coil
  initial begin
    pos_count = 0;
    neg_count = 0;
    clash_count = 0;
  end
  always @(posedge mclk) begin
    if (pdm_out_pos === 1'b1) pos_count++;
    if (pdm_out_neg === 1'b1) neg_count++;
    if (pdm_out_pos === 1'b1 && pdm_out_neg === 1'b1) clash_count++;
  end
endmodule
`default_nettype wire

// *** test_pdm_audio_dac_control.sv ***
// Self-checking bench for the PDM audio DAC controller
`timescale 1ns/1ps
`default_nettype none
module test_pdm_audio_dac_control;
  import pdmdac_pkg::*;
  logic           mclk, arst_n, halver, lpm, settle;
  pdmdac_io_req_t req;
  logic [15:0]    rdata, vec;
  logic           fready, irq, wake, pos, neg;
  int             failures, comparisons, pc, nc, cc, n, p0, q0, i;

  pdmdac_top dut (.mclk(mclk), .arst_n(arst_n), .io_req(req), .io_rdata(rdata),
    .sample_fifo_ready(fready), .pdm_rate_halver(halver), .low_power_mode(lpm),
    .wake_settling(settle), .sample_tick_irq(irq), .sample_irq_vector(vec),
    .wake_request(wake), .pdm_out_pos(pos), .pdm_out_neg(neg));
  pdmdac_speaker spk (.mclk(mclk), .pdm_out_pos(pos), .pdm_out_neg(neg),
    .pos_count(pc), .neg_count(nc), .clash_count(cc));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk);
    req.wr = 1'b0;
    // Idle cycle so a following call never retoggles a strobe in one step
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge mclk);
    req.rd = 1'b0;
    check(rdata === exp, "read data");
    @(negedge mclk);
  endtask
  // Cycles until the next sample tick; a hang ends the run
  task automatic wait_irq;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      test_done;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check(pos === 1'b0 && neg === 1'b0, "pins idle");
    check(vec === SAMPLE_IRQ_VECTOR, "vector");
    rd(ADDR_DAC_CONTROL, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_regs;
    wr(ADDR_DAC_CONTROL, 16'hfffb);
    rd(ADDR_DAC_CONTROL, 16'h000b);
    rd(ADDR_SAMPLE_DATA, 16'h0000);
    wr(ADDR_DAC_CONTROL, 16'h0000);
    $display("register test done");
  endtask
  // Period of the tick for a control code and halver setting
  task automatic per(input logic [3:0] c, input logic h, input int exp);
    wr(ADDR_DAC_CONTROL, 16'h0000);
    halver = h;
    wr(ADDR_DAC_CONTROL, {12'h000, c | 4'h4});
    wait_irq;
    wait_irq;
    check(n === exp, "tick period");
  endtask
  // Pulse counts over one full period after the sample is loaded
  task automatic dens(input logic [3:0] c, input logic [15:0] s, input int ep, input int en);
    wr(ADDR_DAC_CONTROL, 16'h0000);
    // Full-rate ticks: one pin cycle per PDM tick keeps counts equal to density
    halver = 1'b1;
    wr(ADDR_SAMPLE_DATA, s);
    wr(ADDR_DAC_CONTROL, {12'h000, c | 4'h4});
    wait_irq;
    wait_irq;
    p0 = pc;
    q0 = nc;
    wait_irq;
    check(pc - p0 === ep && nc - q0 === en && cc === 0, "pulse density");
  endtask
  task automatic t_disable;
    dens(4'h0, 16'h6000, 256, 0);
    wr(ADDR_DAC_CONTROL, 16'h0000);
    @(negedge mclk);
    p0 = pc;
    repeat (20) @(negedge mclk);
    check(pos === 1'b0 && pc - p0 === 0, "pins held at zero");
    wr(ADDR_DAC_CONTROL, 16'h0004);
    wait_irq;
    // 257 negedges from the enabling edge to the tick, two of them spent inside wr
    check(n === 255, "restart from zero state");
    $display("disable test done");
  endtask
  task automatic t_fifo;
    wr(ADDR_DAC_CONTROL, 16'h0000);
    for (i = 0; i < SAMPLE_FIFO_DEPTH; i++) wr(ADDR_SAMPLE_DATA, 16'h0000);
    @(negedge mclk);
    check(fready === 1'b0, "fifo full");
    wr(ADDR_SAMPLE_DATA, 16'h1000);
    wr(ADDR_DAC_CONTROL, 16'h0004);
    wait_irq;
    @(negedge mclk);
    check(fready === 1'b1, "fifo drains");
    // Drain fully so the dropped word would show up as pulses
    repeat (SAMPLE_FIFO_DEPTH + 1) wait_irq;
    p0 = pc;
    wait_irq;
    check(pc - p0 === 0, "refused word dropped");
    $display("fifo test done");
  endtask
  task automatic t_wake;
    lpm = 1'b1;
    p0 = 0;
    repeat (300) begin
      @(negedge mclk);
      if (wake === 1'b1) p0++;
    end
    check(p0 === 1, "wake pulse");
    lpm = 1'b0;
    settle = 1'b1;
    q0 = 0;
    repeat (600) begin
      @(negedge mclk);
      if (irq === 1'b1 || wake === 1'b1) q0++;
    end
    check(q0 === 0, "tick lost while settling");
    settle = 1'b0;
    $display("wake test done");
  endtask

  // ------------------------------------------------------------
  // Clock, reset and sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    arst_n = 1'b0;
    halver = 1'b1;
    lpm = 1'b0;
    settle = 1'b0;
    req = '0;
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    t_reset;
    t_regs;
    per(4'h0, 1'b1, 256);
    per(4'h1, 1'b1, 512);
    per(4'h2, 1'b1, 1024);
    per(4'h3, 1'b1, 1024);
    per(4'h0, 1'b0, 512);
    $display("period test done");
    dens(4'h0, 16'h1000, 128, 0);
    dens(4'h0, 16'h901f, 0, 128);
    dens(4'h1, 16'h1ff0, 511, 0);
    dens(4'h0, 16'h2000, 256, 0);
    dens(4'h8, 16'h6000, 0, 0);
    $display("density test done");
    t_disable;
    t_fifo;
    t_wake;
    test_done;
  end
endmodule
`default_nettype wire
